// [shared/iorw_pkg.sv]
package iorw_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register indices on the register port.
    localparam logic [7:0] REG_REFRESH  = 8'h11;
    localparam logic [7:0] REG_DOUT_OFF = 8'h13;
    localparam logic [7:0] REG_DIN_OFF  = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;

    // Reset values; zero selects automatic placement and no short refresh.
    localparam logic [15:0] RST_REFRESH  = 16'h0000;
    localparam logic [15:0] RST_DOUT_OFF = 16'h0000;
    localparam logic [15:0] RST_DIN_OFF  = 16'h0000;

    // Field positions of the refresh register.
    localparam int REFR_PERIOD_LSB = 0;
    localparam int REFR_RETRY_LSB  = 8;

    // Field positions of the status register.
    localparam int ST_DROPPED  = 0;
    localparam int ST_BUS_ERR  = 1;
    localparam int ST_OVL_OUT  = 2;
    localparam int ST_OVL_IN   = 3;
    localparam int ST_SHORT_EN = 4;

    // Timing.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_NS        = 1000000;
    localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam logic [15:0] WD_BASE_MS     = 16'h0064;
    localparam logic [7:0]  REFRESH_MAX_MS = 8'h50;

    typedef enum logic {
        WD_RUN,
        WD_DROPPED
    } iorw_wd_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } iorw_req_s;

    typedef struct packed {
        logic [15:0] refresh;
        logic [15:0] dout_off;
        logic [15:0] din_off;
        logic [31:0] tick_cnt;
        logic [7:0]  ms_cnt;
        logic [15:0] wd_ms;
        logic [7:0]  retry_left;
        iorw_wd_e    wd;
        logic        refresh_pulse;
        logic        outputs_en;
        logic [15:0] rdata;
        logic [15:0] dout_base;
        logic [15:0] din_base;
    } iorw_state_s;

endpackage

// [core/iorw_top.sv]
//
// Functional notes
// - Output bits start at digital-output offset register.
// - Input bits start at digital-input offset register.
// - Default offsets place bits after byte data.
// - Refresh per program cycle; late cycle drops outputs.
// - Low byte period capped 80 ms, high byte retries.
// - Short refreshes extend timeout to retries times period when that exceeds the 100 ms base.
// - Terminal bus error keeps timeout at base value.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module iorw_top #(
    parameter int TICK_CYCLES = iorw_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Register port.
    input  wire iorw_pkg::iorw_req_s reg_req,
    output var  logic [15:0]       reg_rdata,
    // Process image layout.
    input  wire logic [15:0]       byte_in_len,
    input  wire logic [15:0]       byte_out_len,
    output var  logic [15:0]       dout_base,
    output var  logic [15:0]       din_base,
    // Terminal bus refresh and watchdog.
    input  wire logic              prog_cycle,
    input  wire logic              kbus_error,
    output var  logic              kbus_refresh,
    output var  logic              outputs_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Refresh period in milliseconds, capped at the allowed maximum.
    function automatic logic [7:0] eff_period(input logic [15:0] r);
        logic [7:0] p;
        p = r[iorw_pkg::REFR_PERIOD_LSB +: 8];
        if (p > iorw_pkg::REFRESH_MAX_MS) begin
            p = iorw_pkg::REFRESH_MAX_MS;
        end
        return p;
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    iorw_pkg::iorw_state_s st_q;
    iorw_pkg::iorw_state_s st_d;

    logic [7:0]  period;
    logic [7:0]  retries;
    logic        short_en;
    logic [15:0] ext_ms;
    logic [15:0] limit_ms;
    logic        tick;
    logic        inter_due;

    always_comb begin
        period   = eff_period(st_q.refresh);
        retries  = st_q.refresh[iorw_pkg::REFR_RETRY_LSB +: 8];
        short_en = (st_q.refresh != 16'h0000) && (period != 8'h00);
        ext_ms   = 16'(retries) * 16'(period);
        if (short_en && !kbus_error && ext_ms > iorw_pkg::WD_BASE_MS) begin
            limit_ms = ext_ms;
        end else begin
            limit_ms = iorw_pkg::WD_BASE_MS;
        end
        tick      = (st_q.tick_cnt == 32'(TICK_CYCLES - 1));
        inter_due = tick && short_en && !kbus_error
                    && (st_q.retry_left != 8'h00)
                    && (st_q.ms_cnt + 8'h01 >= period);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_d               = st_q;
        st_d.refresh_pulse = 1'b0;
        st_d.rdata         = 16'h0000;

        // Register writes.
        if (reg_req.wr) begin
            case (reg_req.addr)
                iorw_pkg::REG_REFRESH:  st_d.refresh  = reg_req.wdata;
                iorw_pkg::REG_DOUT_OFF: st_d.dout_off = reg_req.wdata;
                iorw_pkg::REG_DIN_OFF:  st_d.din_off  = reg_req.wdata;
                default: ;
            endcase
        end

        // Register reads answer one cycle later; unmapped reads give zero.
        if (reg_req.rd) begin
            case (reg_req.addr)
                iorw_pkg::REG_REFRESH:  st_d.rdata = st_q.refresh;
                iorw_pkg::REG_DOUT_OFF: st_d.rdata = st_q.dout_off;
                iorw_pkg::REG_DIN_OFF:  st_d.rdata = st_q.din_off;
                iorw_pkg::REG_STATUS: begin
                    st_d.rdata[iorw_pkg::ST_DROPPED]  =
                        (st_q.wd == iorw_pkg::WD_DROPPED);
                    st_d.rdata[iorw_pkg::ST_BUS_ERR]  = kbus_error;
                    st_d.rdata[iorw_pkg::ST_OVL_OUT]  =
                        byte_out_len > st_q.dout_base;
                    st_d.rdata[iorw_pkg::ST_OVL_IN]   =
                        byte_in_len > st_q.din_base;
                    st_d.rdata[iorw_pkg::ST_SHORT_EN] = short_en;
                end
                default: st_d.rdata = 16'h0000;
            endcase
        end

        st_d.dout_base = (st_q.dout_off != 16'h0000) ? st_q.dout_off
                                                     : byte_out_len;
        st_d.din_base  = (st_q.din_off != 16'h0000) ? st_q.din_off
                                                    : byte_in_len;

        // Millisecond time base.
        st_d.tick_cnt = tick ? 32'h0 : st_q.tick_cnt + 32'h1;

        if (prog_cycle) begin
            st_d.refresh_pulse = 1'b1;
            st_d.ms_cnt        = 8'h00;
            st_d.wd_ms         = 16'h0000;
            st_d.retry_left    = retries;
            st_d.wd            = iorw_pkg::WD_RUN;
            st_d.outputs_en    = 1'b1;
        end else begin
            if (tick) begin
                st_d.wd_ms  = sat_inc(st_q.wd_ms);
                st_d.ms_cnt = st_q.ms_cnt + 8'h01;
            end
            if (inter_due) begin
                st_d.refresh_pulse = 1'b1;
                st_d.ms_cnt        = 8'h00;
                st_d.retry_left    = st_q.retry_left - 8'h01;
            end
            case (st_q.wd)
                iorw_pkg::WD_RUN: begin
                    if (st_q.wd_ms >= limit_ms) begin
                        st_d.wd         = iorw_pkg::WD_DROPPED;
                        st_d.outputs_en = 1'b0;
                    end
                end
                iorw_pkg::WD_DROPPED: st_d.outputs_en = 1'b0;
                default: st_d.wd = iorw_pkg::WD_DROPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q               <= '0;
            st_q.refresh       <= iorw_pkg::RST_REFRESH;
            st_q.dout_off      <= iorw_pkg::RST_DOUT_OFF;
            st_q.din_off       <= iorw_pkg::RST_DIN_OFF;
            st_q.wd            <= iorw_pkg::WD_RUN;
            st_q.outputs_en    <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata      = st_q.rdata;
    assign dout_base      = st_q.dout_base;
    assign din_base       = st_q.din_base;
    assign kbus_refresh   = st_q.refresh_pulse;
    assign outputs_enable = st_q.outputs_en;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_dout_off;
        (st_q.dout_off != 16'h0000) |=> dout_base == $past(st_q.dout_off);
    endproperty
    a_dout_off: assert property (p_dout_off)
        else $error("output bit start not at offset");

    property p_din_off;
        (st_q.din_off != 16'h0000) |=> din_base == $past(st_q.din_off);
    endproperty
    a_din_off: assert property (p_din_off)
        else $error("input bit start not at offset");

    property p_auto_place;
        (st_q.dout_off == 16'h0000) && (st_q.din_off == 16'h0000) |=>
            dout_base == $past(byte_out_len) && din_base == $past(byte_in_len);
    endproperty
    a_auto_place: assert property (p_auto_place)
        else $error("default placement not after byte data");

    property p_prog_refresh;
        prog_cycle |=> kbus_refresh && outputs_enable;
    endproperty
    a_prog_refresh: assert property (p_prog_refresh)
        else $error("program cycle gave no refresh");

    property p_inter_cause;
        kbus_refresh && !$past(prog_cycle) |->
            $past(short_en) && $past(st_q.retry_left) != 8'h00
            && !$past(kbus_error) && $past(period) <= 8'h50;
    endproperty
    a_inter_cause: assert property (p_inter_cause)
        else $error("intermediate refresh without cause");

    property p_ext_timeout;
        $fell(outputs_enable) |->
            $past(st_q.wd_ms) >= $past(limit_ms)
            && ($past(short_en) && !$past(kbus_error)
                && $past(ext_ms) > 16'h0064 ?
                $past(limit_ms) == $past(ext_ms) : 1'b1);
    endproperty
    a_ext_timeout: assert property (p_ext_timeout)
        else $error("outputs dropped before extended timeout");

    property p_err_base;
        kbus_error |-> limit_ms == 16'h0064 && !inter_due;
    endproperty
    a_err_base: assert property (p_err_base)
        else $error("bus error did not keep base timeout");

    property p_zero_off;
        (st_q.refresh == 16'h0000) && !prog_cycle |=> !kbus_refresh;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("refresh while intermediate refresh disabled");

    c_inter: cover property (kbus_refresh && !$past(prog_cycle));
    c_drop: cover property ($fell(outputs_enable));
    c_err_drop: cover property (kbus_error && $fell(outputs_enable));

endmodule

`default_nettype wire

// [tb/iorw_term_model.sv]
`timescale 1ns/10ps
`default_nettype none

module iorw_term_model (
    // Clock.
    input  wire logic        ref_clk,
    // Terminal bus.
    input  wire logic        kbus_refresh,
    input  wire logic        outputs_enable,
    // Observation.
    output var  logic [15:0] refresh_cnt,
    output var  logic        outputs_live
);
    logic [15:0] cnt_q = 16'h0000;

    always @(posedge ref_clk) begin
        if (kbus_refresh === 1'b1) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign refresh_cnt = cnt_q;

    always_comb outputs_live = (outputs_enable === 1'b1);
endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int TICK = 10;
    logic                ref_clk;
    logic                reset_n;
    iorw_pkg::iorw_req_s reg_req;
    logic [15:0]         reg_rdata;
    logic [15:0]         byte_in_len;
    logic [15:0]         byte_out_len;
    logic [15:0]         dout_base;
    logic [15:0]         din_base;
    logic                prog_cycle;
    logic                kbus_error;
    logic                kbus_refresh;
    logic                outputs_enable;
    logic [15:0]         refresh_cnt;
    logic                outputs_live;
    logic [15:0]         rd_val;
    logic [15:0]         cnt0;
    int                  err_total;
    int                  total_checks;

    iorw_top #(.TICK_CYCLES(TICK)) u_iorw_top (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .byte_in_len(byte_in_len),
        .byte_out_len(byte_out_len), .dout_base(dout_base),
        .din_base(din_base), .prog_cycle(prog_cycle),
        .kbus_error(kbus_error), .kbus_refresh(kbus_refresh),
        .outputs_enable(outputs_enable)
    );

    iorw_term_model u_iorw_term_model (
        .ref_clk(ref_clk), .kbus_refresh(kbus_refresh),
        .outputs_enable(outputs_enable), .refresh_cnt(refresh_cnt),
        .outputs_live(outputs_live)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [15:0] data);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        data = reg_rdata;
    endtask

    task automatic wait_ms(input int n);
        repeat (n * TICK) @(posedge ref_clk);
        #1;
    endtask

    // Runs one program cycle and watches refreshes and the output drop.
    task automatic run_wd(input logic [15:0] refr, input logic err,
                          input int hi_ms, input int lo_ms,
                          input logic [15:0] nref);
        wr(iorw_pkg::REG_REFRESH, refr);
        kbus_error <= err;
        @(posedge ref_clk);
        prog_cycle <= 1'b1;
        @(posedge ref_clk);
        prog_cycle <= 1'b0;
        #1;
        cnt0 = refresh_cnt;
        chk("outputs_enable after cycle", 16'h0001, {15'h0, outputs_live});
        wait_ms(hi_ms);
        chk("outputs_enable before limit", 16'h0001, {15'h0, outputs_live});
        wait_ms(lo_ms - hi_ms);
        chk("outputs_enable after limit", 16'h0000, {15'h0, outputs_live});
        chk("refresh count", nref, refresh_cnt - cnt0);
        kbus_error <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #900000;
        err_total++;
        close_out();
    end

    initial begin
        err_total = 0;
        total_checks = 0;
        reset_n = 1'b0;
        reg_req = '0;
        byte_in_len = 16'h0008;
        byte_out_len = 16'h0008;
        prog_cycle = 1'b0;
        kbus_error = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(iorw_pkg::REG_REFRESH, rd_val);
        chk("refresh reset", 16'h0000, rd_val);
        rd(iorw_pkg::REG_DOUT_OFF, rd_val);
        chk("dout offset reset", 16'h0000, rd_val);
        rd(iorw_pkg::REG_DIN_OFF, rd_val);
        chk("din offset reset", 16'h0000, rd_val);
        rd(8'h20, rd_val);
        chk("unmapped read", 16'h0000, rd_val);
        chk("dout_base auto", 16'h0008, dout_base);
        chk("din_base auto", 16'h0008, din_base);
        byte_out_len <= 16'h000c;
        byte_in_len <= 16'h000a;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("dout_base shifted", 16'h000c, dout_base);
        chk("din_base shifted", 16'h000a, din_base);
        wr(iorw_pkg::REG_DOUT_OFF, 16'h0014);
        wr(iorw_pkg::REG_DIN_OFF, 16'h001e);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("dout_base fixed", 16'h0014, dout_base);
        chk("din_base fixed", 16'h001e, din_base);
        rd(iorw_pkg::REG_DOUT_OFF, rd_val);
        chk("dout offset readback", 16'h0014, rd_val);
        rd(iorw_pkg::REG_DIN_OFF, rd_val);
        chk("din offset readback", 16'h001e, rd_val);
        run_wd(16'h0000, 1'b0, 95, 105, 16'h0001);
        run_wd(16'h0350, 1'b0, 235, 250, 16'h0004);
        rd(iorw_pkg::REG_REFRESH, rd_val);
        chk("refresh readback", 16'h0350, rd_val);
        run_wd(16'h0350, 1'b1, 95, 105, 16'h0001);
        run_wd(16'h0164, 1'b0, 95, 105, 16'h0002);
        run_wd(16'h0264, 1'b0, 155, 170, 16'h0003);
        rd(iorw_pkg::REG_STATUS, rd_val);
        chk("status after drop", 16'h0011, rd_val);
        byte_out_len <= 16'h0018;
        byte_in_len <= 16'h0020;
        rd(iorw_pkg::REG_STATUS, rd_val);
        chk("status overlap", 16'h001d, rd_val);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("outputs_enable after reset", 16'h0001, {15'h0, outputs_live});
        rd(iorw_pkg::REG_REFRESH, rd_val);
        chk("refresh after reset", 16'h0000, rd_val);
        chk("dout_base after reset", 16'h0018, dout_base);
        close_out();
    end
endmodule

`default_nettype wire
